// ==== src/dhcs_dev.sv ====
// Device end: register slice, interrupt pin, indirect window, formatter.
// Assumes a host holding req until ack, and same-clock user-side logic.
//
// Added by the designer: register access over the req/ack link from the host.
`timescale 1ns/1ns
module dhcs_dev
  import dhcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  dhcs_if.dev bus,
  input wire logic [7:0] irq_status,
  output logic [9:0] ind_addr,
  output logic ind_req,
  output logic ind_we,
  output logic [15:0] ind_wdata,
  input wire logic [15:0] ind_rdata,
  input wire logic ind_ack,
  output dhcs_mode_t out_mode,
  output logic sync_mod_en,
  output logic parity_excl,
  output logic anc_en,
  output logic bit_swap,
  output logic [9:0] start_pixel,
  input wire logic sync_valid,
  input wire logic sync_f,
  input wire logic sync_v,
  input wire logic sync_h,
  input wire logic scaled,
  output logic [7:0] sync_code,
  output logic sync_code_valid,
  input wire logic anc_start,
  input wire logic field,
  input wire logic [9:0] line_num,
  input wire logic [7:0] eav_id_unscaled,
  input wire logic [7:0] eav_id_scaled,
  output logic [7:0] anc_byte,
  output logic anc_valid
);
  typedef enum logic [1:0] {I_IDLE, I_BUSY} dhcs_ist_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] cfg;
    logic [7:0] outc;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [7:0] alo;
    logic [7:0] stb;
    logic [7:0] pix_hi;
    logic [PIX_LO_W-1:0] pix_lo;
    logic [9:0] pix;
    dhcs_ist_t ist;
    logic ireq;
    logic iwe;
    logic [9:0] iaddr;
    logic ack;
    logic [7:0] rdata;
    logic irq_o;
    logic irq_oe_n;
    logic pbusy;
    logic [3:0] pidx;
    logic [7:0] packet_data_identifier;
    logic [9:0] lnum;
    logic [7:0] abyte;
    logic avalid;
    logic [7:0] scode;
    logic svalid;
  } dhcs_dev_t;

  dhcs_dev_t r_ff, nxt_r;

  function automatic logic [7:0] swap8(input logic [7:0] b, input logic sw);
    logic [7:0] o;
    o = b;
    if (sw) begin
      for (int i = 0; i < 8; i++) begin
        o[i] = b[7-i];
      end
    end
    return o;
  endfunction

  function automatic logic [7:0] pkt_byte(input logic [3:0] i, input logic [7:0] packet_data_identifier,
    input logic [9:0] ln);
    logic [7:0] ln_hi;
    logic [7:0] cs;
    ln_hi = {6'h00, ln[9:8]};
    cs = packet_data_identifier + PKT_PACKET_SECONDARY_IDENTIFIER + PKT_NN + ln[7:0] + ln_hi + PKT_DATA + PKT_DATA;
    case (i)
      4'h0: pkt_byte = PKT_PRE0;
      4'h1, 4'h2: pkt_byte = PKT_PRE1;
      4'h3: pkt_byte = packet_data_identifier;
      4'h4: pkt_byte = PKT_PACKET_SECONDARY_IDENTIFIER;
      4'h5: pkt_byte = PKT_NN;
      4'h6: pkt_byte = ln[7:0];
      4'h7: pkt_byte = ln_hi;
      4'h8, 4'h9: pkt_byte = PKT_DATA;
      4'hA: pkt_byte = cs;
      default: pkt_byte = PKT_FILL;
    endcase
  endfunction

  logic irq_active;
  logic [3:0] nib;
  logic [7:0] did_c;
  logic msb;
  logic [3:0] prot;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.ack = 1'b0;
    // Mask gates the pin only; status stays outside and untouched
    irq_active = |(irq_status & r_ff.en);
    if (r_ff.cfg[POL_BIT]) begin
      nxt_r.irq_o = irq_active;
      nxt_r.irq_oe_n = 1'b0;
    end else begin
      nxt_r.irq_o = 1'b0;
      nxt_r.irq_oe_n = !irq_active;
    end
    // Register access; stalled while an indirect access runs
    if (bus.req && !r_ff.ack && r_ff.ist == I_IDLE) begin
      nxt_r.ack = 1'b1;
      if (bus.we) begin
        case (bus.addr)
          A_IRQ_EN: nxt_r.en = bus.wdata;
          A_IRQ_CFG: nxt_r.cfg = bus.wdata;
          A_OUT_CTL: nxt_r.outc = bus.wdata;
          A_IND_DLO: nxt_r.dlo = bus.wdata;
          A_IND_DHI: nxt_r.dhi = bus.wdata;
          A_IND_ADR: nxt_r.alo = bus.wdata;
          A_PIX_HI: nxt_r.pix_hi = bus.wdata;
          A_PIX_LO: begin
            nxt_r.pix_lo = bus.wdata[PIX_LO_W-1:0];
            nxt_r.pix = {r_ff.pix_hi, bus.wdata[1:0]};
          end
          A_IND_STB: begin
            nxt_r.stb = bus.wdata;
            nxt_r.ist = I_BUSY;
            nxt_r.ireq = 1'b1;
            case (bus.wdata)
              STB_RD0: {nxt_r.iaddr, nxt_r.iwe} = {BANK0 | {2'h0, r_ff.alo}, 1'b0};
              STB_WR0: {nxt_r.iaddr, nxt_r.iwe} = {BANK0 | {2'h0, r_ff.alo}, 1'b1};
              STB_RD2: {nxt_r.iaddr, nxt_r.iwe} = {BANK2 | {2'h0, r_ff.alo}, 1'b0};
              STB_WR2: {nxt_r.iaddr, nxt_r.iwe} = {BANK2 | {2'h0, r_ff.alo}, 1'b1};
              STB_RD3: {nxt_r.iaddr, nxt_r.iwe} = {BANK3 | {2'h0, r_ff.alo}, 1'b0};
              STB_WR3: {nxt_r.iaddr, nxt_r.iwe} = {BANK3 | {2'h0, r_ff.alo}, 1'b1};
              default: begin
                // Unknown code starts nothing
                nxt_r.ist = I_IDLE;
                nxt_r.ireq = 1'b0;
              end
            endcase
          end
          default: ;
        endcase
      end else begin
        case (bus.addr)
          A_IRQ_EN: nxt_r.rdata = r_ff.en;
          A_IRQ_CFG: nxt_r.rdata = r_ff.cfg;
          A_OUT_CTL: nxt_r.rdata = r_ff.outc;
          A_IND_DLO: nxt_r.rdata = r_ff.dlo;
          A_IND_DHI: nxt_r.rdata = r_ff.dhi;
          A_IND_ADR: nxt_r.rdata = r_ff.alo;
          A_IND_STB: nxt_r.rdata = r_ff.stb;
          A_PIX_HI: nxt_r.rdata = r_ff.pix_hi;
          A_PIX_LO: nxt_r.rdata = {5'h00, r_ff.pix_lo};
          default: nxt_r.rdata = RST_REG;
        endcase
      end
    end
    // Indirect access completes on the far side's ack
    if (r_ff.ist == I_BUSY && ind_ack) begin
      nxt_r.ist = I_IDLE;
      nxt_r.ireq = 1'b0;
      if (!r_ff.iwe) begin
        nxt_r.dlo = ind_rdata[7:0];
        nxt_r.dhi = ind_rdata[15:8];
      end
    end
    // Sync code: XY byte with optional MSB and parity modification
    msb = r_ff.outc[SYNC_MOD_BIT] ? !scaled : 1'b1;
    prot = {sync_v ^ sync_h, sync_f ^ sync_h, sync_f ^ sync_v, sync_f ^ sync_v ^ sync_h};
    if (!r_ff.outc[PAR_MOD_BIT] && !msb) begin
      prot = ~prot;
    end
    nxt_r.svalid = sync_valid;
    if (sync_valid) begin
      nxt_r.scode = swap8({msb, sync_f, sync_v, sync_h, prot}, r_ff.outc[SWAP_BIT]);
    end
    // Ancillary packet
    nib = scaled ? (field ? eav_id_scaled[7:4] : eav_id_scaled[3:0])
                 : (field ? eav_id_unscaled[7:4] : eav_id_unscaled[3:0]);
    did_c = {!(^{DID_FIXED, nib}), ^{DID_FIXED, nib}, DID_FIXED, nib};
    nxt_r.avalid = 1'b0;
    if (!r_ff.pbusy && anc_start && r_ff.outc[ANC_EN_BIT]) begin
      nxt_r.pbusy = 1'b1;
      nxt_r.pidx = 4'h0;
      nxt_r.packet_data_identifier = did_c;
      nxt_r.lnum = line_num;
    end else if (r_ff.pbusy) begin
      nxt_r.avalid = 1'b1;
      nxt_r.abyte = swap8(pkt_byte(r_ff.pidx, r_ff.packet_data_identifier, r_ff.lnum), r_ff.outc[SWAP_BIT]);
      nxt_r.pidx = r_ff.pidx + 4'h1;
      if (r_ff.pidx == PKT_LEN - 4'h1) begin
        nxt_r.pbusy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
      r_ff.ist <= I_IDLE;
      r_ff.irq_oe_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign bus.rdata = r_ff.rdata;
  assign bus.ack = r_ff.ack;
  assign bus.irq_o = r_ff.irq_o;
  assign bus.irq_oe_n = r_ff.irq_oe_n;
  assign ind_addr = r_ff.iaddr;
  assign ind_req = r_ff.ireq;
  assign ind_we = r_ff.iwe;
  assign ind_wdata = {r_ff.dhi, r_ff.dlo};
  assign out_mode = dhcs_mode_t'(r_ff.outc[OM_LSB +: 3]);
  assign sync_mod_en = r_ff.outc[SYNC_MOD_BIT];
  assign parity_excl = r_ff.outc[PAR_MOD_BIT];
  assign anc_en = r_ff.outc[ANC_EN_BIT];
  assign bit_swap = r_ff.outc[SWAP_BIT];
  assign start_pixel = r_ff.pix;
  assign sync_code = r_ff.scode;
  assign sync_code_valid = r_ff.svalid;
  assign anc_byte = r_ff.abyte;
  assign anc_valid = r_ff.avalid;
endmodule

// ==== src/dhcs_host.sv ====
// Host end: APB-programmed controller issuing device register accesses.
// Assumes the device acks each request; interrupt wire is asynchronous.
`timescale 1ns/1ns
module dhcs_host
  import dhcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  dhcs_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_seen
);
  typedef enum logic [1:0] {H_IDLE, H_REQ} dhcs_hst_t;

  typedef struct packed {
    dhcs_hst_t st;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic pend;
    logic [7:0] pend_lo;
    logic pol;
    logic s1;
    logic s2;
    logic s3;
    logic irq_lvl;
  } dhcs_host_t;

  dhcs_host_t r_ff, nxt_r;
  logic acc;
  logic busy;

  always_comb begin
    nxt_r = r_ff;
    acc = psel && penable;
    busy = r_ff.st != H_IDLE || r_ff.pend;
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    // Three-stage sampling of the interrupt wire
    nxt_r.s1 = bus.irq_line;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    if (r_ff.s2 == r_ff.s3) begin
      nxt_r.irq_lvl = r_ff.s3;
    end
    case (paddr)
      H_CMD: begin
        prdata = {15'h0000, r_ff.we, r_ff.addr, r_ff.wdata};
        if (acc && pwrite) begin
          if (busy) begin
            pslverr = 1'b1;
          end else begin
            nxt_r.st = H_REQ;
            nxt_r.req = 1'b1;
            nxt_r.we = pwdata[CMD_WE_BIT];
            nxt_r.addr = pwdata[15:8];
            nxt_r.wdata = pwdata[7:0];
          end
        end
      end
      H_STAT: prdata = {22'h000000, r_ff.irq_lvl == r_ff.pol, busy, r_ff.rdata};
      H_CFG: begin
        prdata = {31'h0000_0000, r_ff.pol};
        if (acc && pwrite) begin
          nxt_r.pol = pwdata[0];
        end
      end
      H_PIX: begin
        if (acc && pwrite) begin
          if (busy) begin
            pslverr = 1'b1;
          end else begin
            // High part first, low part queued behind it
            nxt_r.st = H_REQ;
            nxt_r.req = 1'b1;
            nxt_r.we = 1'b1;
            nxt_r.addr = A_PIX_HI;
            nxt_r.wdata = pwdata[9:2];
            nxt_r.pend = 1'b1;
            nxt_r.pend_lo = {6'h00, pwdata[1:0]};
          end
        end
      end
      default: pslverr = acc;
    endcase
    if (r_ff.st == H_REQ && bus.ack) begin
      nxt_r.req = 1'b0;
      nxt_r.st = H_IDLE;
      if (!r_ff.we) begin
        nxt_r.rdata = bus.rdata;
      end
      if (r_ff.pend) begin
        // Low write applies the staged start value
        nxt_r.pend = 1'b0;
        nxt_r.st = H_REQ;
        nxt_r.req = 1'b1;
        nxt_r.addr = A_PIX_LO;
        nxt_r.wdata = r_ff.pend_lo;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
      r_ff.st <= H_IDLE;
      r_ff.s1 <= 1'b1;
      r_ff.s2 <= 1'b1;
      r_ff.s3 <= 1'b1;
      r_ff.irq_lvl <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pready = 1'b1;
  assign irq_seen = r_ff.irq_lvl == r_ff.pol;
  assign bus.req = r_ff.req;
  assign bus.we = r_ff.we;
  assign bus.addr = r_ff.addr;
  assign bus.wdata = r_ff.wdata;
endmodule

// ==== src/dhcs_if.sv ====
// Carrier between the host controller and the device register slice.
// Resolves the open-drain interrupt wire with a pull-up.
`timescale 1ns/1ns
interface dhcs_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic irq_o;
  logic irq_oe_n;
  logic irq_line;
  assign irq_line = irq_oe_n ? 1'b1 : irq_o;
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack,
    output irq_o, output irq_oe_n);
  modport host (output req, output we, output addr, output wdata, input rdata,
    input ack, input irq_line);
endinterface

// ==== src/dhcs_pkg.sv ====
// Shared constants and types for the decoder host control slice.
// Assumes one 50 MHz clock shared by both ends.
package dhcs_pkg;
  // Device register offsets
  localparam logic [7:0] A_IRQ_EN = 8'h1D;
  localparam logic [7:0] A_IRQ_CFG = 8'h1E;
  localparam logic [7:0] A_OUT_CTL = 8'h1F;
  localparam logic [7:0] A_IND_DLO = 8'h21;
  localparam logic [7:0] A_IND_DHI = 8'h22;
  localparam logic [7:0] A_IND_ADR = 8'h23;
  localparam logic [7:0] A_IND_STB = 8'h24;
  localparam logic [7:0] A_PIX_HI = 8'h25;
  localparam logic [7:0] A_PIX_LO = 8'h26;
  localparam logic [7:0] RST_REG = 8'h00;
  // Field positions
  localparam int POL_BIT = 0;
  localparam int OM_LSB = 0;
  localparam int SYNC_MOD_BIT = 3;
  localparam int PAR_MOD_BIT = 4;
  localparam int ANC_EN_BIT = 5;
  localparam int SWAP_BIT = 6;
  localparam int PIX_LO_W = 3;
  // Strobe codes
  localparam logic [7:0] STB_RD0 = 8'h01;
  localparam logic [7:0] STB_WR0 = 8'h02;
  localparam logic [7:0] STB_RD2 = 8'h03;
  localparam logic [7:0] STB_WR2 = 8'h04;
  localparam logic [7:0] STB_RD3 = 8'h05;
  localparam logic [7:0] STB_WR3 = 8'h06;
  localparam logic [9:0] BANK0 = 10'h000;
  localparam logic [9:0] BANK2 = 10'h200;
  localparam logic [9:0] BANK3 = 10'h300;
  // Output modes
  typedef enum logic [2:0] {
    OM_UNSCALED = 3'h0,
    OM_SCALED = 3'h1,
    OM_MUX_SEP = 3'h2,
    OM_MUX_54 = 3'h3,
    OM_TOGGLE = 3'h4
  } dhcs_mode_t;
  // Ancillary packet
  localparam logic [3:0] PKT_LEN = 4'hC;
  localparam logic [7:0] PKT_PRE0 = 8'h00;
  localparam logic [7:0] PKT_PRE1 = 8'hFF;
  localparam logic [7:0] PKT_PACKET_SECONDARY_IDENTIFIER = 8'h80;
  localparam logic [7:0] PKT_NN = 8'h41;
  localparam logic [7:0] PKT_DATA = 8'h00;
  localparam logic [7:0] PKT_FILL = 8'h80;
  localparam logic [1:0] DID_FIXED = 2'h1;
  // Host APB map
  localparam logic [11:0] H_CMD = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam logic [11:0] H_CFG = 12'h008;
  localparam logic [11:0] H_PIX = 12'h00C;
  localparam int CMD_WE_BIT = 16;
endpackage

// ==== test/dhcs_asserts.sv ====
// Checker on the link between host controller and device slice.
// Assumes it sits beside the one interface joining the two ends.
`timescale 1ns/1ns
module dhcs_asserts
  import dhcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic irq_o,
  input wire logic irq_oe_n
);
  logic [7:0] en_ff, cfg_ff, ctl_ff, adr_ff;
  logic pol_ff;
  // Shadows follow acked writes; pol_ff lags to cover pin latency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_ff <= RST_REG;
      cfg_ff <= RST_REG;
      ctl_ff <= RST_REG;
      adr_ff <= RST_REG;
      pol_ff <= 1'b0;
    end else begin
      if (ack && we && addr == A_IRQ_EN) en_ff <= wdata;
      if (ack && we && addr == A_IRQ_CFG) cfg_ff <= wdata;
      if (ack && we && addr == A_OUT_CTL) ctl_ff <= wdata;
      if (ack && we && addr == A_IND_ADR) adr_ff <= wdata;
      pol_ff <= cfg_ff[POL_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_pend;
    req && !ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    ack && !we && addr == a;
  endsequence
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack held past one cycle");
  ack_req_a: assert property (ack |-> req && $past(req))
    else $error("ack without a held request");
  ack_bound_a: assert property (s_pend |-> ##[0:40] ack)
    else $error("request never answered");
  en_read_a: assert property (s_rd(A_IRQ_EN) |-> rdata == en_ff)
    else $error("enable readback wrong");
  cfg_read_a: assert property (s_rd(A_IRQ_CFG) |-> rdata == cfg_ff)
    else $error("config readback wrong");
  ctl_read_a: assert property (s_rd(A_OUT_CTL) |-> rdata == ctl_ff)
    else $error("output control readback wrong");
  adr_read_a: assert property (s_rd(A_IND_ADR) |-> rdata == adr_ff)
    else $error("indirect address readback wrong");
  pol_low_a: assert property (!cfg_ff[POL_BIT] && !pol_ff |-> !irq_o)
    else $error("pin driven high in low polarity");
  pol_high_a: assert property (cfg_ff[POL_BIT] && pol_ff |-> !irq_oe_n)
    else $error("pin released in high polarity");
endmodule

// ==== test/testbench.sv ====
// Testbench: APB-driven host controller joined to the device slice.
// Assumes the package map; the bench plays the indirect register file.
`timescale 1ns/1ns
module testbench
  import dhcs_pkg::*;
;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq_seen;
  logic ind_req, ind_we, ind_ack, anc_start, field, scaled, anc_valid;
  logic sync_mod_en, parity_excl, anc_en, bit_swap, lwe, err;
  logic sync_valid, sync_f, sync_v, sync_h, sync_code_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] irq_status, eav_u, eav_s, anc_byte, v, d, cs, rv, sync_code;
  logic [9:0] ind_addr, start_pixel, line_num, la, ea;
  logic [15:0] ind_wdata, ind_rdata, lw, w;
  logic [7:0] ra [10];
  logic [7:0] e [12];
  dhcs_mode_t out_mode;
  int bad_count, checks_done, ind_n, n, k;
  dhcs_if i_dhcs_if();
  dhcs_host i_dhcs_host (.clk(clk), .arst_n(arst_n), .bus(i_dhcs_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_seen(irq_seen));
  dhcs_dev i_dhcs_dev (.clk(clk), .arst_n(arst_n), .bus(i_dhcs_if), .irq_status(irq_status),
    .ind_addr(ind_addr), .ind_req(ind_req), .ind_we(ind_we), .ind_wdata(ind_wdata),
    .ind_rdata(ind_rdata), .ind_ack(ind_ack), .out_mode(out_mode), .sync_mod_en(sync_mod_en),
    .parity_excl(parity_excl), .anc_en(anc_en), .bit_swap(bit_swap),
    .start_pixel(start_pixel), .sync_valid(sync_valid), .sync_f(sync_f), .sync_v(sync_v),
    .sync_h(sync_h), .scaled(scaled), .sync_code(sync_code), .sync_code_valid(sync_code_valid),
    .anc_start(anc_start), .field(field), .line_num(line_num), .eav_id_unscaled(eav_u),
    .eav_id_scaled(eav_s), .anc_byte(anc_byte), .anc_valid(anc_valid));
  dhcs_asserts i_dhcs_asserts (.clk(clk), .arst_n(arst_n), .req(i_dhcs_if.req),
    .we(i_dhcs_if.we), .addr(i_dhcs_if.addr), .wdata(i_dhcs_if.wdata),
    .rdata(i_dhcs_if.rdata), .ack(i_dhcs_if.ack), .irq_o(i_dhcs_if.irq_o),
    .irq_oe_n(i_dhcs_if.irq_oe_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Indirect file: answers one cycle after request, logs the access
  always @(posedge clk) begin
    ind_ack <= ind_req && !ind_ack;
    if (ind_req && !ind_ack) begin
      ind_rdata <= {~ind_addr[7:0], 6'h00, ind_addr[9:8]};
      la <= ind_addr;
      lwe <= ind_we;
      lw <= ind_wdata;
      ind_n <= ind_n + 1;
    end
  end
  task conclude;
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    // Woken before the edge's updates land, so these are the sampled values
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      bad_count++;
      $display("Error %0t: bus answer timed out", $time);
      conclude();
    end
  endtask
  // Poll busy so no command lands while one is in flight
  task idle;
    int t;
    t = 0;
    do begin
      apb(1'b0, H_STAT, 32'h0);
      t++;
    end while (rd[8] !== 1'b0 && t < 30);
    if (t >= 30) begin
      bad_count++;
      $display("Error %0t: controller stayed busy", $time);
      conclude();
    end
  endtask
  task dw(input logic [7:0] a, input logic [7:0] dt);
    apb(1'b1, H_CMD, {15'h0, 1'b1, a, dt});
    idle();
  endtask
  task dr(input logic [7:0] a);
    apb(1'b1, H_CMD, {16'h0, a, 8'h00});
    idle();
    v = rd[7:0];
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    $display("Error %0t: run timed out", $time);
    conclude();
  end
  initial begin
    {arst_n, psel, penable, pwrite, sync_valid, anc_start, field, scaled} = 8'h00;
    {paddr, pwdata, irq_status, eav_u, eav_s, line_num, sync_f, sync_v, sync_h} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    ra = '{A_IRQ_EN, A_IRQ_CFG, A_OUT_CTL, A_IND_DLO, A_IND_DHI, A_IND_ADR, A_IND_STB,
      A_PIX_HI, 8'h20, 8'h40};
    foreach (ra[i]) begin
      dr(ra[i]);
      chk(16'(v), 16'h0);
    end
    for (int m = 0; m < 5; m++) begin
      d = {1'b0, {4{m[0]}}, m[2:0]};
      dw(A_OUT_CTL, d);
      chk(16'(out_mode), 16'(m));
      chk(16'({bit_swap, anc_en, parity_excl, sync_mod_en}), {12'h0, {4{m[0]}}});
      dr(A_OUT_CTL);
      chk(16'(v), 16'(d));
    end
    irq_status <= 8'h10;
    repeat (8) @(negedge clk);
    chk(16'(i_dhcs_if.irq_line), 16'h1);
    dw(A_IRQ_EN, 8'h10);
    repeat (8) @(negedge clk);
    chk(16'({i_dhcs_if.irq_line, i_dhcs_if.irq_oe_n}), 16'h0);
    apb(1'b0, H_STAT, 32'h0);
    chk(16'(rd[9]), 16'h1);
    chk(16'(irq_seen), 16'h1);
    dw(A_IRQ_EN, 8'hEF);
    repeat (8) @(negedge clk);
    chk(16'(i_dhcs_if.irq_line), 16'h1);
    dw(A_IRQ_EN, 8'h10);
    dw(A_IRQ_CFG, 8'h01);
    apb(1'b1, H_CFG, 32'h1);
    chk(16'(err), 16'h0);
    repeat (8) @(negedge clk);
    chk(16'({i_dhcs_if.irq_line, i_dhcs_if.irq_oe_n}), 16'h2);
    irq_status <= 8'h00;
    repeat (8) @(negedge clk);
    chk(16'({i_dhcs_if.irq_line, i_dhcs_if.irq_oe_n}), 16'h0);
    apb(1'b0, H_STAT, 32'h0);
    chk(16'(rd[9]), 16'h0);
    chk(16'(irq_seen), 16'h0);
    dw(A_IND_ADR, 8'h34);
    dw(A_IND_DLO, 8'h78);
    dw(A_IND_DHI, 8'h56);
    w = 16'h5678;
    for (int c = 1; c < 8; c++) begin
      n = ind_n;
      dw(A_IND_STB, 8'(c));
      ea = (c < 3) ? 10'h034 : (c < 5) ? 10'h234 : 10'h334;
      if (c == 7) begin
        chk(16'(ind_n - n), 16'h0);
      end else begin
        chk(16'(ind_n - n), 16'h1);
        chk(16'(la), 16'(ea));
        chk(16'(lwe), 16'(c % 2 == 0));
        if (c % 2 == 0) begin
          chk(lw, w);
        end else begin
          w = {~ea[7:0], 6'h00, ea[9:8]};
          dr(A_IND_DLO);
          chk(16'(v), 16'(w[7:0]));
          dr(A_IND_DHI);
          chk(16'(v), 16'(w[15:8]));
        end
      end
    end
    dw(A_PIX_HI, 8'hAB);
    chk(16'(start_pixel), 16'h0);
    dw(A_PIX_LO, 8'h03);
    chk(16'(start_pixel), 16'h2AF);
    apb(1'b1, H_PIX, 32'h155);
    // A second order while the pair is in flight must be refused
    apb(1'b1, H_CMD, {15'h0, 1'b1, A_PIX_LO, 8'h00});
    chk(16'(err), 16'h1);
    idle();
    chk(16'(start_pixel), 16'h155);
    for (int p = 0; p < 2; p++) begin
      dw(A_OUT_CTL, p ? 8'h60 : 8'h20);
      ea = p ? 10'h2C5 : 10'h13A;
      field <= 1'(p);
      scaled <= 1'(p);
      line_num <= ea;
      eav_u <= 8'hA3 + 8'(p);
      eav_s <= 8'h5C + 8'(p);
      d = {4'h1, p ? 4'h5 : 4'h3};
      d[6] = ^d[5:0];
      d[7] = ~d[6];
      cs = d + 8'h80 + 8'h41 + ea[7:0] + {6'h0, ea[9:8]};
      e = '{8'h00, 8'hFF, 8'hFF, d, 8'h80, 8'h41, ea[7:0], {6'h0, ea[9:8]}, 8'h00, 8'h00,
        cs, 8'h80};
      @(posedge clk);
      anc_start <= 1'b1;
      @(posedge clk);
      anc_start <= 1'b0;
      n = 0;
      k = 0;
      while (k < 12 && n < 20) begin
        @(negedge clk);
        n++;
        if (anc_valid === 1'b1) begin
          rv = {<<{e[k]}};
          chk(16'(anc_byte), 16'(p ? rv : e[k]));
          k++;
        end
      end
      // One cycle while the start is taken, then twelve bytes
      chk(16'(n), 16'd13);
      @(negedge clk);
      chk(16'(anc_valid), 16'h0);
    end
    // Sync byte: F=1 V=0 H=1 on scaled data, modifier and parity swept
    for (int q = 0; q < 4; q++) begin
      dw(A_OUT_CTL, 8'(q << 3));
      {sync_f, sync_v, sync_h, scaled} <= 4'hB;
      @(posedge clk);
      sync_valid <= 1'b1;
      @(posedge clk);
      sync_valid <= 1'b0;
      @(negedge clk);
      d = {~q[0], 7'h5A};
      if (q[1] == 0 && q[0] == 1) begin
        d[3:0] = 4'h5;
      end
      chk(16'({sync_code_valid, sync_code}), {7'h0, 1'b1, d});
    end
    conclude();
  end
endmodule
